// [logic/dcrac_pkg.sv]
// Package with constants, types and carriers of the compatible-mode DMA register block.
package dcrac_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int GRANT_MIN_NS  = 300;
  localparam int GRANT_LONG_NS = 600;
  localparam logic [6:0] GRANT_MIN_CYC  = 7'((GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] GRANT_LONG_CYC = 7'((GRANT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [15:0] ARB_OFS     = 16'h0090;
  localparam logic [15:0] LO_BASE     = 16'h0000;
  localparam logic [15:0] HI_CH_BASE  = 16'h00C0;
  localparam logic [15:0] HI_CTL_BASE = 16'h00D0;
  localparam logic [15:0] PAGE_BASE   = 16'h0080;
  localparam logic [7:0][3:0] PAGE_LO = {4'hA, 4'h9, 4'hB, 4'hF, 4'h2, 4'h1, 4'h3, 4'h7};

  localparam logic [2:0] IDX_STAT   = 3'h0;
  localparam logic [2:0] IDX_SMASK  = 3'h2;
  localparam logic [2:0] IDX_MODE   = 3'h3;
  localparam logic [2:0] IDX_CLRBP  = 3'h4;
  localparam logic [2:0] IDX_MCLR   = 3'h5;
  localparam logic [2:0] IDX_UNMASK = 3'h6;
  localparam logic [2:0] IDX_WMASK  = 3'h7;

  localparam int ARB_NOHOLD_BIT = 7;
  localparam int ARB_DIS_BIT    = 6;
  localparam int ARB_EXT_BIT    = 5;
  localparam int SMASK_VAL_BIT  = 2;

  localparam logic       ARB_NOHOLD_RST = 1'b0;
  localparam logic       ARB_DIS_RST    = 1'b1;
  localparam logic       ARB_EXT_RST    = 1'b0;
  localparam logic [7:0] MASK_RST       = 8'hFF;
  localparam logic [1:0] MODE_RST       = 2'h0;
  localparam logic [7:0] WIDE_CHANS     = 8'hF0;
  localparam logic [15:0] FIXED_IO_ADDR = 16'h0000;
  localparam logic       HOLD_RST       = 1'b0;
  localparam logic       GRANT_OUT_RST  = 1'b1;
  localparam logic       TIMEOUT_RST    = 1'b0;
  localparam logic       ARB_ACT_RST    = 1'b0;
  localparam logic [3:0] LEVEL_RST      = 4'h0;
  localparam logic [6:0] GRANT_CNT_RST  = 7'h00;
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] RDATA_RST      = 8'h00;
  localparam logic [1:0] BPTR_RST       = 2'h0;

  typedef enum logic [3:0] {
    K_NONE, K_ADDR, K_CNT, K_PAGE, K_STAT, K_SMASK, K_MODE,
    K_CLRBP, K_MCLR, K_UNMASK, K_WMASK, K_ARB
  } dcrac_kind_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dcrac_io_s;

  typedef struct packed {
    dcrac_kind_e kind;
    logic        grp;
    logic [2:0]  ch;
  } dcrac_dec_s;

endpackage

// [logic/dcrac_top.sv]
// Compatible-mode DMA register file, status, masks and arbitration control.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Arbitration bit 7 set keeps hold request low during arbitration.
// - Bit 7 clear, CPU not owner: hold stays up until arbitration ends; resets zero.
// - Bit 6 set disables arbitration and drives grant output high; resets one.
// - NMI sets bit 6; writing zero to bit 6 clears it, releasing grant output.
// - Bit 5 written one stretches minimum grant cycle from 300 to 600 ns.
// - Bit 5 reads bus time-out flag, cleared by bit 6 zero write or reset.
// - Bits 3-0 read last winning level; software writes bits 4-0 as zero.
// - Channels 0-3 are 8 bit, 4-7 are 16 bit, I/O address fixed zero.
// - Status bits 3-0 flag terminal count, cleared by reset and status read.
// - Status bits 7-4 set when channel owned the bus, cleared by reset or read.
// - Status bit n is channel n or n+4 count, bit n+4 its request.
// - Per-channel mask blocks requests; all masks set after reset.
// - Single mask write sets or clears one mask by bit 2, channel in bits 1-0.
// - Write-all-masks loads four group masks from data bits 3-0.
// - Master clear write clears group status and masks the group.
// - Clear-mask write unmasks every channel of the group.
// - Clear-byte-pointer write points the group pointer at the low byte.
// - Memory address is two bytes, low then high through one location.
// - Transfer count is two bytes, low then high through one location.
// - Page byte per channel gives address bits 23-16, read and write.
// - Mode write picks channel by bits 1-0, operation by bits 3-2.
module dcrac_top (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire dcrac_pkg::dcrac_io_s  io_req,
  output logic [7:0]                 io_rdata_ff,
  input  wire logic [7:0]            terminal_count_event,
  input  wire logic [7:0]            bus_own_event,
  input  wire logic                  nmi_event,
  input  wire logic                  bus_timeout_event,
  input  wire logic                  grant_valid,
  input  wire logic [3:0]            grant_level,
  input  wire logic                  arb_cycle_active,
  input  wire logic                  cpu_owns_bus,
  output logic                       hold_req_ff,
  output logic                       arbitration_grant_out_ff,
  output logic [7:0]                 chan_mask_ff,
  output logic [7:0]                 chan_is_16bit_ff,
  output logic [15:0]                io_port_addr_ff,
  output logic [7:0][1:0]            chan_mode_op_ff,
  output logic [7:0][15:0]           mem_addr_ff,
  output logic [7:0][15:0]           xfer_count_ff,
  output logic [7:0][7:0]            page_ff
);
  import dcrac_pkg::*;

  function automatic dcrac_kind_e ctl_kind(input logic [2:0] idx);
    dcrac_kind_e k;
    k = K_NONE;
    unique case (idx)
      IDX_STAT:   k = K_STAT;
      IDX_SMASK:  k = K_SMASK;
      IDX_MODE:   k = K_MODE;
      IDX_CLRBP:  k = K_CLRBP;
      IDX_MCLR:   k = K_MCLR;
      IDX_UNMASK: k = K_UNMASK;
      IDX_WMASK:  k = K_WMASK;
      default:    k = K_NONE;
    endcase
    return k;
  endfunction

  function automatic dcrac_dec_s decode(input logic [15:0] a);
    dcrac_dec_s d;
    d.kind = K_NONE;
    d.grp  = 1'b0;
    d.ch   = 3'h0;
    if (a == ARB_OFS) begin
      d.kind = K_ARB;
    end else if (a[15:4] == LO_BASE[15:4] && !a[3]) begin
      d.kind = a[0] ? K_CNT : K_ADDR;
      d.ch   = {1'b0, a[2:1]};
    end else if (a[15:4] == LO_BASE[15:4]) begin
      d.kind = ctl_kind(a[2:0]);
    end else if (a[15:4] == HI_CH_BASE[15:4] && !a[0]) begin
      d.kind = a[1] ? K_CNT : K_ADDR;
      d.ch   = {1'b1, a[3:2]};
      d.grp  = 1'b1;
    end else if (a[15:4] == HI_CTL_BASE[15:4] && !a[0]) begin
      d.kind = ctl_kind(a[3:1]);
      d.grp  = 1'b1;
    end else if (a[15:4] == PAGE_BASE[15:4]) begin
      for (int i = 0; i < 8; i++) begin
        if (a[3:0] == PAGE_LO[i]) begin
          d.kind = K_PAGE;
          d.ch   = 3'(i);
          d.grp  = d.ch[2];
        end
      end
    end
    return d;
  endfunction

  dcrac_dec_s dec;
  logic       wr_hit;
  logic       rd_hit;
  logic [1:0] byte_ptr_ff;
  logic       arb_nohold_ff;
  logic       arb_disable_ff;
  logic       arb_long_ff;
  logic       bus_timeout_ff;
  logic [3:0] win_level_ff;
  logic       arb_act_d_ff;
  logic [6:0] gnt_cnt_ff;
  logic [7:0] terminal_count_flag_ff;
  logic [7:0] chan_req_flag_ff;
  logic [7:0] stat_clr;
  logic [7:0] grp_chans;
  logic [7:0] rd_value;
  logic       bp_cur;
  logic       arb_clr_wr;

  assign dec        = decode(io_req.addr);
  assign wr_hit     = io_req.wr;
  assign rd_hit     = io_req.rd;
  assign grp_chans  = dec.grp ? 8'hF0 : 8'h0F;
  assign bp_cur     = byte_ptr_ff[dec.grp];
  assign arb_clr_wr = wr_hit && dec.kind == K_ARB && !io_req.wdata[ARB_DIS_BIT];
  assign stat_clr   = ((rd_hit && dec.kind == K_STAT) || (wr_hit && dec.kind == K_MCLR)) ? grp_chans : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_nohold_ff <= ARB_NOHOLD_RST;
    end else if (wr_hit && dec.kind == K_ARB) begin
      arb_nohold_ff <= io_req.wdata[ARB_NOHOLD_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_disable_ff <= ARB_DIS_RST;
    end else if (nmi_event) begin
      arb_disable_ff <= 1'b1;
    end else if (wr_hit && dec.kind == K_ARB) begin
      arb_disable_ff <= io_req.wdata[ARB_DIS_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_long_ff <= ARB_EXT_RST;
    end else if (wr_hit && dec.kind == K_ARB) begin
      arb_long_ff <= io_req.wdata[ARB_EXT_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_timeout_ff <= TIMEOUT_RST;
    end else if (bus_timeout_event) begin
      bus_timeout_ff <= 1'b1;
    end else if (arb_clr_wr) begin
      bus_timeout_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_level_ff <= LEVEL_RST;
    end else if (grant_valid) begin
      win_level_ff <= grant_level;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_act_d_ff <= ARB_ACT_RST;
    end else begin
      arb_act_d_ff <= arb_cycle_active;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gnt_cnt_ff <= GRANT_CNT_RST;
    end else if (arb_cycle_active && !arb_act_d_ff) begin
      gnt_cnt_ff <= arb_long_ff ? GRANT_LONG_CYC : GRANT_MIN_CYC;
    end else if (gnt_cnt_ff != 7'h00) begin
      gnt_cnt_ff <= gnt_cnt_ff - 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_req_ff <= HOLD_RST;
    end else begin
      hold_req_ff <= arb_cycle_active && !arb_nohold_ff && !cpu_owns_bus;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arbitration_grant_out_ff <= GRANT_OUT_RST;
    end else begin
      arbitration_grant_out_ff <= arb_disable_ff || arb_cycle_active || gnt_cnt_ff > 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      terminal_count_flag_ff <= STATUS_RST;
    end else begin
      terminal_count_flag_ff <= (terminal_count_flag_ff & ~stat_clr) | terminal_count_event;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_req_flag_ff <= STATUS_RST;
    end else begin
      chan_req_flag_ff <= (chan_req_flag_ff & ~stat_clr) | bus_own_event;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_mask_ff <= MASK_RST;
    end else if (wr_hit) begin
      unique case (dec.kind)
        K_SMASK: chan_mask_ff[{dec.grp, io_req.wdata[1:0]}] <= io_req.wdata[SMASK_VAL_BIT];
        K_WMASK: begin
          if (dec.grp) begin
            chan_mask_ff[7:4] <= io_req.wdata[3:0];
          end else begin
            chan_mask_ff[3:0] <= io_req.wdata[3:0];
          end
        end
        K_MCLR:   chan_mask_ff <= chan_mask_ff | grp_chans;
        K_UNMASK: chan_mask_ff <= chan_mask_ff & ~grp_chans;
        default:  chan_mask_ff <= chan_mask_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_mode_op_ff <= {8{MODE_RST}};
    end else if (wr_hit && dec.kind == K_MODE) begin
      chan_mode_op_ff[{dec.grp, io_req.wdata[1:0]}] <= io_req.wdata[3:2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_is_16bit_ff <= WIDE_CHANS;
    end else begin
      chan_is_16bit_ff <= WIDE_CHANS;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_port_addr_ff <= FIXED_IO_ADDR;
    end else begin
      io_port_addr_ff <= FIXED_IO_ADDR;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_ptr_ff <= BPTR_RST;
    end else if (wr_hit && (dec.kind == K_CLRBP || dec.kind == K_MCLR)) begin
      byte_ptr_ff[dec.grp] <= 1'b0;
    end else if ((wr_hit || rd_hit) && (dec.kind == K_ADDR || dec.kind == K_CNT)) begin
      byte_ptr_ff[dec.grp] <= !bp_cur;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_hit && dec.kind == K_ADDR) begin
      if (bp_cur) begin
        mem_addr_ff[dec.ch][15:8] <= io_req.wdata;
      end else begin
        mem_addr_ff[dec.ch][7:0] <= io_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_hit && dec.kind == K_CNT) begin
      if (bp_cur) begin
        xfer_count_ff[dec.ch][15:8] <= io_req.wdata;
      end else begin
        xfer_count_ff[dec.ch][7:0] <= io_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_hit && dec.kind == K_PAGE) begin
      page_ff[dec.ch] <= io_req.wdata;
    end
  end

  always_comb begin
    rd_value = 8'h00;
    unique case (dec.kind)
      K_ADDR:  rd_value = bp_cur ? mem_addr_ff[dec.ch][15:8] : mem_addr_ff[dec.ch][7:0];
      K_CNT:   rd_value = bp_cur ? xfer_count_ff[dec.ch][15:8] : xfer_count_ff[dec.ch][7:0];
      K_PAGE:  rd_value = page_ff[dec.ch];
      K_STAT: begin
        if (dec.grp) begin
          rd_value = {chan_req_flag_ff[7:4], terminal_count_flag_ff[7:4]};
        end else begin
          rd_value = {chan_req_flag_ff[3:0], terminal_count_flag_ff[3:0]};
        end
      end
      K_ARB:   rd_value = {arb_nohold_ff, arb_disable_ff, bus_timeout_ff, 1'b0, win_level_ff};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata_ff <= RDATA_RST;
    end else if (rd_hit) begin
      io_rdata_ff <= rd_value;
    end
  end

endmodule
`default_nettype wire

// [dv/dcrac_host.sv]
// Host processor model that issues single I/O register cycles.
`timescale 1ns/100ps
`default_nettype none
module dcrac_host import dcrac_pkg::*; (
  input  wire logic                 ref_clk,
  output var  dcrac_pkg::dcrac_io_s io_req,
  input  wire logic [7:0]           io_rdata_ff
);
  initial io_req = '0;
  // Holds the request for one edge, then shows inverted lines while idle.
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    io_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    io_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1;
    q = io_rdata_ff;
  endtask
endmodule
`default_nettype wire

// [dv/dcrac_top_asserts.sv]
// Checker of mask, mode and arbitration behaviour at the block's ports.
`timescale 1ns/100ps
`default_nettype none
module dcrac_chk import dcrac_pkg::*; (
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  input wire dcrac_pkg::dcrac_io_s io_req,
  input wire logic                 nmi_event,
  input wire logic                 arb_cycle_active,
  input wire logic                 cpu_owns_bus,
  input wire logic                 hold_req_ff,
  input wire logic                 arbitration_grant_out_ff,
  input wire logic [7:0]           chan_mask_ff,
  input wire logic [7:0][1:0]      chan_mode_op_ff
);
  logic nohold_ff, dis_ff, ext_ff;
  wire logic [15:0] a = io_req.addr;
  wire logic [7:0] d = io_req.wdata;
  wire logic w = io_req.wr;
  wire logic arb_w = w && a == ARB_OFS;
  wire logic cause = rst_b && arb_cycle_active && !cpu_owns_bus && !nohold_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nohold_ff <= 1'b0;
      ext_ff <= 1'b0;
    end else if (arb_w) begin
      nohold_ff <= d[7];
      ext_ff <= d[5];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dis_ff <= 1'b1;
    end else if (arb_w || nmi_event) begin
      dis_ff <= nmi_event || d[6];
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  hold_block_a:
    assert property ($past(nohold_ff) |-> !hold_req_ff) else $error("hold while blocked");
  hold_keep_a:
    assert property ($past(cause) |-> hold_req_ff) else $error("hold dropped");
  grant_dis_a:
    assert property ($past(dis_ff) |-> arbitration_grant_out_ff) else $error("grant low while disabled");
  grant_rel_a:
    assert property (arb_w && !d[6] && !nmi_event && !arb_cycle_active |-> ##[1:64] !arbitration_grant_out_ff)
      else $error("grant not released");
  grant_long_a:
    assert property ($rose(arb_cycle_active) && ext_ff |-> ##59 arbitration_grant_out_ff) else $error("grant short");
  mask_rst_a:
    assert property ($rose(rst_b) |-> chan_mask_ff == 8'hFF) else $error("masks not set");
  single_mask_a:
    assert property (w && a == 16'h000A |=> chan_mask_ff[$past(d[1:0])] == $past(d[2])) else $error("single mask");
  all_mask_a:
    assert property (w && a == 16'h00DE |=> chan_mask_ff[7:4] == $past(d[3:0])) else $error("write masks");
  mode_write_a:
    assert property (w && a == 16'h000B |=> chan_mode_op_ff[$past(d[1:0])] == $past(d[3:2])) else $error("mode");
endmodule
bind dcrac_top dcrac_chk u_chk (.*);
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench of the compatible-mode DMA register block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dcrac_pkg::*;
  logic             ref_clk, rst_b, nmi_event, bus_timeout_event, grant_valid, arb_cycle_active, cpu_owns_bus;
  logic             hold_req_ff, arbitration_grant_out_ff;
  logic [3:0]       grant_level;
  logic [7:0]       io_rdata_ff, terminal_count_event, bus_own_event, chan_mask_ff, chan_is_16bit_ff, q;
  logic [15:0]      io_port_addr_ff, r;
  logic [7:0][1:0]  chan_mode_op_ff;
  logic [7:0][15:0] mem_addr_ff, xfer_count_ff, ea, ec;
  logic [7:0][7:0]  page_ff, ep;
  dcrac_io_s        io_req;
  logic [31:0]      seed;
  int               fail_count, checks;
  dcrac_top dut (.*);
  dcrac_host host (.*);
  function automatic logic [15:0] reg_at(input int n, input int c);
    return n < 4 ? 16'(2 * n + c) : 16'(8'hC0 + 4 * (n - 4) + 2 * c);
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd;
    seed = lfsr(seed);
    r = seed[15:0];
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    checks++;
    if (v !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.cyc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host.cyc(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  task automatic tick;
    @(posedge ref_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {rst_b, nmi_event, bus_timeout_event, grant_valid, arb_cycle_active, cpu_owns_bus} = '0;
    {grant_level, terminal_count_event, bus_own_event} = '0;
    seed = 32'h2EED;
    repeat (8) tick();
    rst_b <= 1'b1;
    rd(ARB_OFS, 8'h40);
    rd(16'h0011, 8'h00);
    chk("mask", 16'h00FF, chan_mask_ff);
    chk("wide", 16'h00F0, chan_is_16bit_ff);
    chk("ioaddr", 16'h0000, io_port_addr_ff);
    $display("reset test done");
    wr(16'h000C, 8'h00);
    wr(16'h00D8, 8'h00);
    for (int n = 0; n < 8; n++) begin
      rnd();
      ea[n] = r;
      rnd();
      ec[n] = r;
      ep[n] = r[15:8] ^ r[7:0];
      wr(reg_at(n, 0), ea[n][7:0]);
      wr(reg_at(n, 0), ea[n][15:8]);
      wr(reg_at(n, 1), ec[n][7:0]);
      wr(reg_at(n, 1), ec[n][15:8]);
      wr({12'h008, PAGE_LO[n]}, ep[n]);
    end
    for (int n = 0; n < 8; n++) begin
      rd(reg_at(n, 0), ea[n][7:0]);
      rd(reg_at(n, 0), ea[n][15:8]);
      rd(reg_at(n, 1), ec[n][7:0]);
      rd(reg_at(n, 1), ec[n][15:8]);
      rd({12'h008, PAGE_LO[n]}, ep[n]);
      chk("addr", ea[n], mem_addr_ff[n]);
      chk("count", ec[n], xfer_count_ff[n]);
      chk("page", {8'h00, ep[n]}, {8'h00, page_ff[n]});
    end
    $display("storage test done");
    rnd();
    tick();
    terminal_count_event <= r[7:0];
    bus_own_event <= r[15:8];
    tick();
    {terminal_count_event, bus_own_event} <= '0;
    rd(16'h0008, {r[11:8], r[3:0]});
    rd(16'h00D0, {r[15:12], r[7:4]});
    rd(16'h0008, 8'h00);
    rd(16'h00D0, 8'h00);
    wr(16'h000E, 8'h00);
    wr(16'h00DC, 8'h00);
    chk("unmask", 16'h0000, chan_mask_ff);
    for (int n = 0; n < 8; n++) begin
      wr(n < 4 ? 16'h000A : 16'h00D4, {5'h00, 1'b1, n[1:0]});
      chk("smask", 16'h00FF >> (7 - n), chan_mask_ff);
    end
    wr(16'h000A, 8'h01);
    chk("smask clr", 16'h00FD, chan_mask_ff);
    rnd();
    wr(16'h000F, {4'h0, r[3:0]});
    wr(16'h00DE, {4'h0, r[11:8]});
    chk("wmask", {8'h00, r[11:8], r[3:0]}, chan_mask_ff);
    tick();
    terminal_count_event <= 8'h01;
    tick();
    terminal_count_event <= 8'h00;
    wr(16'h000D, 8'h00);
    rd(16'h0008, 8'h00);
    chk("mclr", {8'h00, r[11:8], 4'hF}, chan_mask_ff);
    for (int k = 0; k < 8; k++) begin
      wr(k < 4 ? 16'h000B : 16'h00D6, {4'h0, 2'(k % 3), 2'(k)});
      chk("mode", 16'(k % 3), chan_mode_op_ff[k]);
    end
    $display("mask test done");
    rnd();
    tick();
    grant_level <= r[3:0];
    {grant_valid, bus_timeout_event} <= 2'b11;
    tick();
    {grant_valid, bus_timeout_event} <= 2'b00;
    rd(ARB_OFS, {4'h6, r[3:0]});
    wr(ARB_OFS, 8'h00);
    rd(ARB_OFS, {4'h0, r[3:0]});
    chk("grant low", 16'h0000, arbitration_grant_out_ff);
    tick();
    arb_cycle_active <= 1'b1;
    repeat (2) tick();
    #1 chk("hold", 16'h0001, hold_req_ff);
    tick();
    cpu_owns_bus <= 1'b1;
    repeat (2) tick();
    #1 chk("cpu owns", 16'h0000, hold_req_ff);
    tick();
    cpu_owns_bus <= 1'b0;
    wr(ARB_OFS, 8'h80);
    tick();
    #1 chk("no hold", 16'h0000, hold_req_ff);
    tick();
    arb_cycle_active <= 1'b0;
    wr(ARB_OFS, 8'h20);
    repeat (40) tick();
    arb_cycle_active <= 1'b1;
    tick();
    arb_cycle_active <= 1'b0;
    repeat (50) tick();
    #1 chk("long grant", 16'h0001, arbitration_grant_out_ff);
    tick();
    nmi_event <= 1'b1;
    tick();
    nmi_event <= 1'b0;
    rd(ARB_OFS, {4'h4, r[3:0]});
    chk("grant dis", 16'h0001, arbitration_grant_out_ff);
    $display("arbitration test done");
    give_verdict();
  end
endmodule
`default_nettype wire
